// ---- core/sps_top.sv ----
// Secondary-side system and address/data control of a two-bus bridge.
// Assumes pins arrive asynchronously; internal arbiter and core logic are outside.
`timescale 1ns/1ps
module sps_top
  import sps_pkg::*;
(
  input  wire logic                i_sys_clk,
  input  wire logic                i_sys_rst,
  input  wire logic                i_ce,
  input  wire logic                i_prim_rst_n,
  input  wire logic                i_sec_rst_ctl,
  input  wire logic                i_rst_mode,
  output logic [NUM_SCLK-1:0]      o_secondary_clock_outputs,
  output logic                     o_sec_rst_n,
  input  wire logic                i_clk_stop_hs_n,
  output logic                     o_clk_stop_hs_out,
  output logic                     o_clk_stop_hs_oe,
  input  wire logic                i_stop_intent,
  output logic                     o_stop_req_seen,
  input  wire logic                i_ext_arb_sel_n,
  input  wire logic                i_req0_n,
  output logic                     o_gnt0_n,
  input  wire logic                i_int_gnt0_n,
  input  wire logic                i_int_bridge_gnt,
  input  wire logic                i_bridge_req,
  output logic                     o_bridge_gnt,
  output logic                     o_ext_arb_on,
  output logic                     o_int_req0_n,
  input  wire sps_lanes_t          i_bus_in,
  output sps_lanes_t               o_bus_out,
  output logic                     o_bus_oe,
  input  wire sps_lanes_t          i_tx,
  input  wire logic                i_tx_oe,
  input  wire logic                i_rx_addr_phase,
  output sps_cap_t                 o_cap,
  output logic [AD_W-1:0]          o_cap_data,
  output logic                     o_cap_valid
);
  typedef struct packed {
    logic       ext_s1, ext_s2;
    logic       req_s1, req_s2;
    logic       run_s1, run_s2;
    logic       prst_s1, prst_s2;
    logic       mode_s1, mode_s2;
    sps_lanes_t bus_s1, bus_s2;
    logic       mode_hold;
    logic       stop_ann;
    logic       gnt0_n;
    logic       bridge_gnt;
    sps_lanes_t tx;
    logic       tx_oe;
    sps_cap_t   cap;
    logic [AD_W-1:0] cap_data;
    logic       cap_valid;
  } sps_st_t;

  sps_st_t st;
  sps_st_t next_st;

  logic            sclk_rise;
  logic            clk_run;
  logic            ext_on;
  logic [AD_W-1:0] masked;

  // Clocks run unless mode hold or an agreed stop on the handshake line
  assign clk_run = !st.mode_hold && !(st.stop_ann && !st.run_s2);
  assign ext_on  = !st.ext_s2;

  sps_clkgen u_clkgen (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_run     (clk_run),
    .o_sclk    (o_secondary_clock_outputs),
    .o_rise    (sclk_rise)
  );

  // Per-lane qualification of sampled data by active-low byte enables
  genvar gb;
  generate
    for (gb = 0; gb < CBE_W; gb++) begin : g_lane
      assign masked[gb*BYTE_W +: BYTE_W] = st.bus_s2.cbe[gb] ? BYTE_OFF
                                           : st.bus_s2.ad[gb*BYTE_W +: BYTE_W];
    end
  endgenerate

  // Next-state logic: synchronisers, mode capture, arbitration, bus lanes
  always_comb begin
    next_st          = st;
    next_st.ext_s1   = i_ext_arb_sel_n;
    next_st.ext_s2   = st.ext_s1;
    next_st.req_s1   = i_req0_n;
    next_st.req_s2   = st.req_s1;
    next_st.run_s1   = i_clk_stop_hs_n;
    next_st.run_s2   = st.run_s1;
    next_st.prst_s1  = !i_prim_rst_n;
    next_st.prst_s2  = st.prst_s1;
    next_st.mode_s1  = i_rst_mode;
    next_st.mode_s2  = st.mode_s1;
    next_st.bus_s1   = i_bus_in;
    next_st.bus_s2   = st.bus_s1;
    // Mode level is caught only while primary reset is seen
    if (st.prst_s2) begin
      next_st.mode_hold = st.mode_s2;
    end
    next_st.stop_ann = i_stop_intent;
    // Arbitration roles swap when the external arbiter is selected
    if (ext_on) begin
      next_st.gnt0_n     = !i_bridge_req;
      next_st.bridge_gnt = !st.req_s2;
    end else begin
      next_st.gnt0_n     = i_int_gnt0_n;
      next_st.bridge_gnt = i_int_bridge_gnt;
    end
    next_st.cap_valid = 1'b0;
    // Drive and sample only at the secondary clock rise
    if (sclk_rise) begin
      next_st.tx                   = i_tx;
      next_st.tx_oe                = i_tx_oe;
      next_st.cap.lanes            = st.bus_s2;
      next_st.cap.addr_phase       = i_rx_addr_phase;
      next_st.cap_data             = i_rx_addr_phase ? st.bus_s2.ad : masked;
      next_st.cap_valid            = 1'b1;
    end
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st            <= '0;
      st.ext_s1     <= 1'b1;
      st.ext_s2     <= 1'b1;
      st.req_s1     <= 1'b1;
      st.req_s2     <= 1'b1;
      st.run_s1     <= 1'b1;
      st.run_s2     <= 1'b1;
      st.gnt0_n     <= 1'b1;
      st.tx         <= '{ad: AD_RESET, cbe: CBE_RESET};
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  // Secondary reset follows primary reset and control combinationally; the mode hold term is registered
  assign o_sec_rst_n       = !(!i_prim_rst_n || i_sec_rst_ctl || st.mode_hold);
  assign o_clk_stop_hs_out = 1'b0;
  assign o_clk_stop_hs_oe  = st.stop_ann;
  assign o_stop_req_seen   = !st.run_s2 && !st.stop_ann;
  assign o_gnt0_n          = st.gnt0_n;
  assign o_bridge_gnt      = st.bridge_gnt;
  assign o_ext_arb_on      = ext_on;
  assign o_int_req0_n      = ext_on ? 1'b1 : st.req_s2;
  assign o_bus_out         = st.tx;
  assign o_bus_oe          = st.tx_oe;
  assign o_cap             = st.cap;
  assign o_cap_data        = st.cap_data;
  assign o_cap_valid       = st.cap_valid;

  // Checks
  property p_rst_or;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (!i_prim_rst_n || i_sec_rst_ctl) |-> !o_sec_rst_n;
  endproperty
  a_rst_or: assert property (p_rst_or) else $error("secondary reset not asserted");

  property p_rst_async;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_prim_rst_n && !i_sec_rst_ctl && !st.mode_hold) |-> o_sec_rst_n;
  endproperty
  a_rst_async: assert property (p_rst_async) else $error("secondary reset stuck");

  property p_mode_off;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (st.mode_hold && i_ce)[*8] |-> (o_secondary_clock_outputs == '0) && !o_sec_rst_n;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("clocks live in mode hold");

  property p_clk_toggle;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (clk_run && i_ce)[*7] |-> (o_secondary_clock_outputs != $past(o_secondary_clock_outputs, 3));
  endproperty
  a_clk_toggle: assert property (p_clk_toggle) else $error("secondary clock not toggling");

  property p_sample;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (sclk_rise && i_ce) |=> o_cap_valid && (o_cap.lanes == $past(st.bus_s2));
  endproperty
  a_sample: assert property (p_sample) else $error("bus not sampled at clock rise");

  property p_announce;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_stop_intent && i_ce) |=> o_clk_stop_hs_oe && !o_clk_stop_hs_out;
  endproperty
  a_announce: assert property (p_announce) else $error("clock stop not announced");

  property p_ext_req;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (ext_on && i_ce) |=> (o_gnt0_n == !$past(i_bridge_req));
  endproperty
  a_ext_req: assert property (p_ext_req) else $error("grant pin not used as request");

  property p_ext_gnt;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (ext_on && !st.req_s2 && i_ce) |=> o_bridge_gnt && !o_int_req0_n == 1'b0;
  endproperty
  a_ext_gnt: assert property (p_ext_gnt) else $error("request pin not used as grant");

  property p_drive;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (sclk_rise && i_ce) |=> (o_bus_out == $past(i_tx)) && (o_bus_oe == $past(i_tx_oe));
  endproperty
  a_drive: assert property (p_drive) else $error("lanes not driven at clock rise");

  property p_lane0;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (o_cap_valid && !o_cap.addr_phase && o_cap.lanes.cbe[0]) |-> (o_cap_data[BYTE_W-1:0] == BYTE_OFF);
  endproperty
  a_lane0: assert property (p_lane0) else $error("disabled byte lane carries data");

  c_ext:  cover property (@(posedge i_sys_clk) disable iff (i_sys_rst) ext_on && o_bridge_gnt);
  c_stop: cover property (@(posedge i_sys_clk) disable iff (i_sys_rst) st.stop_ann && !clk_run);
  c_mode: cover property (@(posedge i_sys_clk) disable iff (i_sys_rst) st.mode_hold);
  c_data: cover property (@(posedge i_sys_clk) disable iff (i_sys_rst)
                          o_cap_valid && !o_cap.addr_phase);
endmodule

// ---- core/sps_pkg.sv ----
// Package for the secondary-side control of a two-bus bridge.
// Assumes a 200 MHz system clock; shared by the top and its clock generator.
package sps_pkg;
  localparam int SYS_CLK_PERIOD_NS = 5;
  localparam int SCLK_HALF_NS      = 15;
  // Least time, so it rounds up to whole cycles (never below one)
  localparam int SCLK_HALF_CYC_I   = (SCLK_HALF_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYC     = (SCLK_HALF_CYC_I < 1) ? 1 : SCLK_HALF_CYC_I;
  localparam int SCLK_CNT_W        = 2;
  localparam logic [SCLK_CNT_W-1:0] SCLK_CNT_LAST = SCLK_CNT_W'(SCLK_HALF_CYC - 1);
  localparam logic [SCLK_CNT_W-1:0] SCLK_CNT_ZERO = 2'h0;

  localparam int NUM_SCLK  = 6;
  localparam int AD_W      = 32;
  localparam int CBE_W     = 4;
  localparam int BYTE_W    = 8;

  localparam logic [AD_W-1:0]  AD_RESET  = 32'h0000_0000;
  localparam logic [CBE_W-1:0] CBE_RESET = 4'h0;
  localparam logic [BYTE_W-1:0] BYTE_OFF = 8'h00;

  // Address/data lane and command/byte-enable lane travelling together
  typedef struct packed {
    logic [AD_W-1:0]  ad;
    logic [CBE_W-1:0] cbe;
  } sps_lanes_t;

  // One sampled bus cycle
  typedef struct packed {
    sps_lanes_t lanes;
    logic       addr_phase;
  } sps_cap_t;

  typedef enum logic {
    SPS_CLK_LOW,
    SPS_CLK_HIGH
  } sps_clk_state_t;
endpackage

// ---- core/sps_clkgen.sv ----
// Secondary bus clock generator: divides the system clock and can stop it.
// Assumes a synchronous reset and a clock enable that freezes the divider.
`timescale 1ns/1ps
module sps_clkgen
  import sps_pkg::*;
(
  input  wire logic                i_sys_clk,
  input  wire logic                i_sys_rst,
  input  wire logic                i_ce,
  input  wire logic                i_run,
  output logic [NUM_SCLK-1:0]      o_sclk,
  output logic                     o_rise
);
  typedef struct packed {
    logic [SCLK_CNT_W-1:0] cnt;
    sps_clk_state_t        phase;
    logic                  rise;
  } sps_gen_st_t;

  sps_gen_st_t st;
  sps_gen_st_t next_st;

  // Half-period counter; clock parks only in its low phase
  always_comb begin
    next_st      = st;
    next_st.rise = 1'b0;
    case (st.phase)
      SPS_CLK_LOW: begin
        if (!i_run) begin
          next_st.cnt = SCLK_CNT_ZERO;
        end else if (st.cnt == SCLK_CNT_LAST) begin
          next_st.cnt   = SCLK_CNT_ZERO;
          next_st.phase = SPS_CLK_HIGH;
          next_st.rise  = 1'b1;
        end else begin
          next_st.cnt = st.cnt + 2'h1;
        end
      end
      SPS_CLK_HIGH: begin
        if (st.cnt == SCLK_CNT_LAST) begin
          next_st.cnt   = SCLK_CNT_ZERO;
          next_st.phase = SPS_CLK_LOW;
        end else begin
          next_st.cnt = st.cnt + 2'h1;
        end
      end
      default: begin
        next_st.phase = SPS_CLK_LOW;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st <= '{cnt: SCLK_CNT_ZERO, phase: SPS_CLK_LOW, rise: 1'b0};
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  // All outputs share one flop so the copies stay in phase
  assign o_sclk = {NUM_SCLK{st.phase == SPS_CLK_HIGH}};
  assign o_rise = st.rise && i_ce;
endmodule

// ---- test/sps_bus_agent.sv ----
// Model of the far side of the secondary bus: another agent and the pull-ups.
// Assumes the bench commands it; released lines never keep their last value.
`timescale 1ns/1ps
module sps_bus_agent
  import sps_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_want_stop,
  input  wire logic       i_want_bus,
  input  wire logic       i_drive,
  input  wire sps_lanes_t i_lanes,
  input  wire logic       i_dev_hs_oe,
  input  wire logic       i_dev_hs_out,
  input  wire logic       i_dev_oe,
  input  wire sps_lanes_t i_dev_lanes,
  output logic            o_hs_n,
  output logic            o_req0_n,
  output sps_lanes_t      o_bus
);
  sps_lanes_t last = '0;
  // Shared clock-run wire: open drain, pulled up, low if either side pulls it low
  assign o_hs_n = ~((i_dev_hs_oe & ~i_dev_hs_out) | i_want_stop);
  // Request pin doubles as grant input in external mode
  assign o_req0_n = ~i_want_bus;
  // Undriven lanes toggle every cycle so nothing stale passes
  always @(posedge i_sys_clk) last <= o_bus;
  assign o_bus = i_dev_oe ? i_dev_lanes : (i_drive ? i_lanes : ~last);
endmodule

// ---- test/sps_top_tb.sv ----
// Self-checking bench for the secondary-side control block.
// Assumes the bus agent model sits on the far side of the pins.
`timescale 1ns/1ps
module sps_top_tb;
  import sps_pkg::*;
  logic clk = 0, rst = 1, prim_n = 1, ctl = 0, mode = 0, intent = 0, ce = 1;
  logic ext_n = 1, igntn = 1, ibg = 0, breq = 0, tx_oe = 0, rxa = 0;
  logic want_stop = 0, want_bus = 0, drive = 0, hs_n, req0_n;
  logic hs_oe, hs_out, seen, gnt0_n, bgnt, ext_on, ireq_n, boe, cvalid, srst_n;
  logic [NUM_SCLK-1:0] sclk;
  logic [AD_W-1:0]     cdata;
  sps_lanes_t          tx = '0, lanes = '0, bus_in, bus_out;
  sps_cap_t            cap;
  int                  num_errors = 0, total_checks = 0, tcnt = 0;

  sps_top uut (.i_sys_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_prim_rst_n(prim_n),
    .i_sec_rst_ctl(ctl), .i_rst_mode(mode), .o_secondary_clock_outputs(sclk),
    .o_sec_rst_n(srst_n), .i_clk_stop_hs_n(hs_n), .o_clk_stop_hs_out(hs_out),
    .o_clk_stop_hs_oe(hs_oe), .i_stop_intent(intent), .o_stop_req_seen(seen),
    .i_ext_arb_sel_n(ext_n), .i_req0_n(req0_n), .o_gnt0_n(gnt0_n), .i_int_gnt0_n(igntn),
    .i_int_bridge_gnt(ibg), .i_bridge_req(breq), .o_bridge_gnt(bgnt), .o_ext_arb_on(ext_on),
    .o_int_req0_n(ireq_n), .i_bus_in(bus_in), .o_bus_out(bus_out), .o_bus_oe(boe),
    .i_tx(tx), .i_tx_oe(tx_oe), .i_rx_addr_phase(rxa), .o_cap(cap), .o_cap_data(cdata),
    .o_cap_valid(cvalid));

  sps_bus_agent agent (.i_sys_clk(clk), .i_want_stop(want_stop), .i_want_bus(want_bus),
    .i_drive(drive), .i_lanes(lanes), .i_dev_hs_oe(hs_oe), .i_dev_hs_out(hs_out),
    .i_dev_oe(boe),
    .i_dev_lanes(bus_out), .o_hs_n(hs_n), .o_req0_n(req0_n), .o_bus(bus_in));

  // 200 MHz system clock
  initial forever #2.5 clk = ~clk;

  // Hang guard
  always @(posedge clk) begin
    tcnt++;
    if (tcnt == 5000) begin
      num_errors++;
      results();
    end
  end

  task automatic results();
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string w, input logic [36:0] s, input logic [36:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", w, e, s);
    end
  endtask

  // Settle just after an edge
  task automatic step();
    @(posedge clk);
    #1;
  endtask

  // Count secondary clock rises over c cycles
  task automatic rises(input int c, output int n);
    logic p;
    n = 0;
    p = sclk[0];
    repeat (c) begin
      step();
      if (sclk !== {NUM_SCLK{sclk[0]}}) n = n + 1000;
      if (sclk[0] === 1'b1 && p !== 1'b1) n++;
      p = sclk[0];
    end
  endtask

  task automatic cap_next();
    step();
    repeat (12) if (cvalid !== 1'b1) step();
    chk("cap_valid", cvalid, 1);
  endtask

  task automatic t_rst();
    int n;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      prim_n <= k[0];
      ctl <= k[1];
      #1 chk("sec_rst_n", srst_n, k[0] & ~k[1]);
    end
    @(posedge clk);
    prim_n <= 0;
    ctl <= 0;
    mode <= 1;
    repeat (8) @(posedge clk);
    prim_n <= 1;
    mode <= 0;
    rises(20, n);
    chk("mode_rst_n", srst_n, 0);
    chk("mode_clk_rises", n, 0);
    @(posedge clk);
    prim_n <= 0;
    repeat (8) @(posedge clk);
    prim_n <= 1;
    repeat (6) step();
    chk("rst_n_released", srst_n, 1);
  endtask

  task automatic t_clk();
    int n;
    logic [NUM_SCLK-1:0] s;
    rises(60, n);
    chk("sclk_rises", n, 10);
    // Clock enable low freezes the divider, high resumes it
    @(posedge clk);
    ce <= 0;
    step();
    s = sclk;
    rises(18, n);
    chk("ce_rises", n, 0);
    chk("ce_hold", sclk, s);
    @(posedge clk);
    ce <= 1;
    rises(30, n);
    chk("ce_resume", n, 5);
  endtask

  task automatic t_bus();
    @(posedge clk);
    drive <= 1;
    lanes <= '{ad: 32'h1122_3344, cbe: 4'h5};
    cap_next();
    cap_next();
    chk("cap_lanes", cap.lanes, {32'h1122_3344, 4'h5});
    chk("cap_masked", cdata, 32'h1100_3300);
    @(posedge clk);
    rxa <= 1;
    lanes <= '{ad: 32'h8000_0010, cbe: 4'h6};
    cap_next();
    cap_next();
    chk("cap_addr", cap, {32'h8000_0010, 4'h6, 1'b1});
    chk("cap_addr_raw", cdata, 32'h8000_0010);
    @(posedge clk);
    rxa <= 0;
    drive <= 0;
    tx <= '{ad: 32'hcafe_0001, cbe: 4'h0};
    tx_oe <= 1;
    cap_next();
    cap_next();
    chk("bus_oe", boe, 1);
    chk("bus_out", bus_out, {32'hcafe_0001, 4'h0});
    chk("own_cap", cdata, 32'hcafe_0001);
    @(posedge clk);
    tx_oe <= 0;
  endtask

  task automatic t_arb();
    @(posedge clk);
    ext_n <= 0;
    breq <= 1;
    repeat (10) step();
    chk("ext_on", {ext_on, ireq_n}, 2'h3);
    chk("gnt0_as_req", gnt0_n, 0);
    @(posedge clk);
    want_bus <= 1;
    repeat (6) step();
    chk("req0_as_gnt", bgnt, 1);
    @(posedge clk);
    want_bus <= 0;
    ext_n <= 1;
    breq <= 0;
    ibg <= 1;
    igntn <= 0;
    repeat (6) step();
    chk("int_arb", {ext_on, bgnt, gnt0_n}, 3'h2);
  endtask

  task automatic t_crun();
    int n;
    @(posedge clk);
    want_stop <= 1;
    repeat (6) step();
    chk("other_stop", {seen, hs_oe}, 2'h2);
    @(posedge clk);
    want_stop <= 0;
    intent <= 1;
    repeat (12) step();
    chk("announce", {hs_oe, hs_out}, 2'h2);
    rises(24, n);
    chk("stopped_rises", n, 0);
    chk("stopped_clk", sclk, 0);
    @(posedge clk);
    intent <= 0;
    rises(30, n);
    chk("restarted", n > 0, 1);
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    repeat (4) @(posedge clk);
    t_rst();
    t_clk();
    t_bus();
    t_arb();
    t_crun();
    results();
  end
endmodule
